/* pkg/tmms_pkg.sv */
// constants, types and helpers shared by the telemetry statistics block
package tmms_pkg;

	localparam int unsigned DW = 10;
	localparam int unsigned SHW = 3;
	localparam int unsigned ACW = DW + 7;
	localparam int unsigned NCH = 4;

	localparam logic [7:0] CMD_VIN_MIN = 8'hD1;
	localparam logic [7:0] CMD_VIN_MAX = 8'hD2;
	localparam logic [7:0] CMD_IIN_MAX = 8'hD4;
	localparam logic [7:0] CMD_TEMP_AVG = 8'hD6;
	localparam logic [7:0] CMD_VOUT_MIN = 8'hDA;
	localparam logic [7:0] CMD_VIN_AVG = 8'hDC;
	localparam logic [7:0] CMD_VOUT_AVG = 8'hDD;
	localparam logic [7:0] CMD_IIN_AVG = 8'hDE;
	localparam logic [7:0] CMD_STAT_CTRL = 8'hD3;
	localparam logic [7:0] CMD_ADC_CFG2 = 8'hE0;

	localparam int unsigned CTL_CNT_LSB = 0;
	localparam int unsigned CTL_MIN_CLR = 5;
	localparam int unsigned CTL_AVG_CLR = 6;
	localparam int unsigned CTL_PK_CLR = 7;
	localparam int unsigned CFG2_AUX_SEL = 7;

	localparam logic [DW-1:0] CODE_ZERO = 10'h000;
	localparam logic [DW-1:0] CODE_MAX = 10'h3FF;
	localparam logic [SHW-1:0] CNT_RST = 3'h0;
	localparam logic [7:0] CFG2_RST = 8'h00;
	localparam logic [7:0] BYTE_NONE = 8'hFF;
	localparam logic [15:0] WORD_ZERO = 16'h0000;

	// channel slots of the averagers
	localparam int unsigned AV_VIN = 0;
	localparam int unsigned AV_VOUT = 1;
	localparam int unsigned AV_IIN = 2;
	localparam int unsigned AV_TMP = 3;
	// channel slots of the extreme trackers
	localparam int unsigned PK_VIN_MIN = 0;
	localparam int unsigned PK_VIN_MAX = 1;
	localparam int unsigned PK_VOUT_MIN = 2;
	localparam int unsigned PK_IIN_MAX = 3;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_CMD  = 3'b010,
		ST_RDHI = 3'b100
	} tmms_state_t;

	function automatic logic [DW-1:0] sat_code(input logic [ACW-1:0] v);
		return (v > ACW'(CODE_MAX)) ? CODE_MAX : v[DW-1:0];
	endfunction

	function automatic logic [15:0] word_of(input logic [DW-1:0] c);
		return {6'h00, c};
	endfunction

endpackage

/* pkg/tmms_stat_if.sv */
// one statistics channel: sample feed, clear and shift in, result out
`timescale 1ns/1ps
`default_nettype none
interface tmms_stat_if #(
	parameter int unsigned DW  = tmms_pkg::DW,
	parameter int unsigned SHW = tmms_pkg::SHW
) ();
	logic           vld;
	logic           clr;
	logic [SHW-1:0] shift;
	logic [DW-1:0]  sample;
	logic [DW-1:0]  result;

	modport ctl (output vld, output clr, output shift, output sample, input result);
	modport avg (input vld, input clr, input shift, input sample, output result);
	modport pk  (input vld, input clr, input sample, output result);
endinterface
`default_nettype wire

/* design/tmms_avg.sv */
// running average of one channel, refreshed on every sample except one that lands with a clear
`timescale 1ns/1ps
`default_nettype none
module tmms_avg (
	input  wire logic core_clk,
	input  wire logic resetn,
	tmms_stat_if.avg  st
);
	logic [tmms_pkg::ACW-1:0] acc_r;
	logic [tmms_pkg::ACW-1:0] acc_nxt;
	logic [tmms_pkg::DW-1:0]  res_r;

	// acc holds average scaled by 2^shift; a shift change mid-run settles over a few blocks
	assign acc_nxt = tmms_pkg::ACW'(acc_r - (acc_r >> st.shift) + tmms_pkg::ACW'(st.sample));
	assign st.result = res_r;

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			acc_r <= '0;
			res_r <= tmms_pkg::CODE_ZERO;
		end else if (st.clr) begin
			acc_r <= '0;
			res_r <= tmms_pkg::CODE_ZERO;
		end else if (st.vld) begin
			acc_r <= acc_nxt;
			res_r <= tmms_pkg::sat_code(acc_nxt >> st.shift);
		end
	end

	avg_track_a: assert property (@(posedge core_clk) disable iff (!resetn)
		st.vld && !st.clr && st.shift == 3'h0 |=> st.result == $past(st.sample))
		else $error("average did not follow sample at unit count");
	avg_hold_a: assert property (@(posedge core_clk) disable iff (!resetn)
		!st.vld && !st.clr |=> $stable(st.result))
		else $error("average moved without a sample");
	avg_long_c: cover property (@(posedge core_clk) disable iff (!resetn)
		st.vld && st.shift == 3'h7);
endmodule
`default_nettype wire

/* design/tmms_peak.sv */
// lowest or highest sample seen since reset or last clear
`timescale 1ns/1ps
`default_nettype none
module tmms_peak #(
	parameter bit IS_MAX = 1'b1
) (
	input  wire logic core_clk,
	input  wire logic resetn,
	tmms_stat_if.pk   st
);
	localparam logic [tmms_pkg::DW-1:0] INIT = IS_MAX ? tmms_pkg::CODE_ZERO : tmms_pkg::CODE_MAX;
	logic [tmms_pkg::DW-1:0] res_r;
	logic                    better;

	assign better = IS_MAX ? (st.sample > res_r) : (st.sample < res_r);
	assign st.result = res_r;

	// a sample landing with the clear is kept so no extreme is lost
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			res_r <= INIT;
		end else if (st.vld && (st.clr || better)) begin
			res_r <= st.sample;
		end else if (st.clr) begin
			res_r <= INIT;
		end
	end

	peak_mono_a: assert property (@(posedge core_clk) disable iff (!resetn)
		!st.clr |=> (IS_MAX ? st.result >= $past(st.result) : st.result <= $past(st.result)))
		else $error("extreme moved the wrong way");
	peak_take_a: assert property (@(posedge core_clk) disable iff (!resetn)
		st.vld && st.clr |=> st.result == $past(st.sample))
		else $error("sample lost at clear");
endmodule
`default_nettype wire

/* design/tmms_top.sv */
// telemetry statistics: averages, minima and maxima read as words
`timescale 1ns/1ps
`default_nettype none
module tmms_top (
	input  wire logic                    core_clk,
	input  wire logic                    resetn,
	input  wire logic                    adc_vld,
	input  wire logic [tmms_pkg::DW-1:0] vin_code,
	input  wire logic [tmms_pkg::DW-1:0] vout_code,
	input  wire logic [tmms_pkg::DW-1:0] iin_code,
	input  wire logic [tmms_pkg::DW-1:0] temp_code,
	input  wire logic [tmms_pkg::DW-1:0] vaux_code,
	input  wire logic                    cmd_vld,
	input  wire logic [7:0]              cmd_code,
	input  wire logic                    wr_vld,
	input  wire logic [7:0]              wr_byte,
	input  wire logic                    rd_req,
	output var  logic [7:0]              rd_byte_r,
	output var  logic                    rd_vld_r,
	output var  logic                    nack_r
);
	localparam int unsigned N = tmms_pkg::NCH;
	localparam logic [N-1:0] PK_IS_MAX = 4'hA;
	localparam logic [N-1:0] PK_ON_MIN = 4'h5;

	tmms_pkg::tmms_state_t state_r;
	tmms_pkg::tmms_state_t state_nxt;

	logic [7:0]              cmd_r;
	logic [15:0]             word_r;
	logic                    known_r;
	logic [tmms_pkg::SHW-1:0] cnt_r;
	logic [7:0]              cfg2_r;
	logic                    clr_avg_r;
	logic                    clr_min_r;
	logic                    clr_pk_r;

	logic [tmms_pkg::DW-1:0] avg_src [N];
	logic [tmms_pkg::DW-1:0] pk_src  [N];
	logic [tmms_pkg::DW-1:0] avg_res [N];
	logic [tmms_pkg::DW-1:0] pk_res  [N];

	wire aux_sel = cfg2_r[tmms_pkg::CFG2_AUX_SEL];

	// sample routing; one averager serves temperature or aux as selected
	assign avg_src[tmms_pkg::AV_VIN]  = vin_code;
	assign avg_src[tmms_pkg::AV_VOUT] = vout_code;
	assign avg_src[tmms_pkg::AV_IIN]  = iin_code;
	assign avg_src[tmms_pkg::AV_TMP]  = aux_sel ? vaux_code : temp_code;
	assign pk_src[tmms_pkg::PK_VIN_MIN]  = vin_code;
	assign pk_src[tmms_pkg::PK_VIN_MAX]  = vin_code;
	assign pk_src[tmms_pkg::PK_VOUT_MIN] = vout_code;
	assign pk_src[tmms_pkg::PK_IIN_MAX]  = iin_code;

	tmms_stat_if avg_if [N] ();
	tmms_stat_if pk_if  [N] ();

	for (genvar i = 0; i < N; i++) begin : g_ch
		assign avg_if[i].vld    = adc_vld;
		assign avg_if[i].clr    = clr_avg_r;
		assign avg_if[i].shift  = cnt_r;
		assign avg_if[i].sample = avg_src[i];
		assign avg_res[i]       = avg_if[i].result;

		assign pk_if[i].vld    = adc_vld;
		assign pk_if[i].clr    = PK_ON_MIN[i] ? clr_min_r : clr_pk_r;
		assign pk_if[i].shift  = cnt_r;
		assign pk_if[i].sample = pk_src[i];
		assign pk_res[i]       = pk_if[i].result;

		tmms_avg u_avg (
			.core_clk (core_clk),
			.resetn   (resetn),
			.st       (avg_if[i])
		);
		tmms_peak #(
			.IS_MAX (PK_IS_MAX[i])
		) u_pk (
			.core_clk (core_clk),
			.resetn   (resetn),
			.st       (pk_if[i])
		);
	end

	// command decode for the read word lookup
	wire c_vin_avg  = cmd_code == tmms_pkg::CMD_VIN_AVG;
	wire c_vout_avg = cmd_code == tmms_pkg::CMD_VOUT_AVG;
	wire c_iin_avg  = cmd_code == tmms_pkg::CMD_IIN_AVG;
	wire c_tmp_avg  = cmd_code == tmms_pkg::CMD_TEMP_AVG;
	wire c_vin_min  = cmd_code == tmms_pkg::CMD_VIN_MIN;
	wire c_vin_max  = cmd_code == tmms_pkg::CMD_VIN_MAX;
	wire c_vout_min = cmd_code == tmms_pkg::CMD_VOUT_MIN;
	wire c_iin_max  = cmd_code == tmms_pkg::CMD_IIN_MAX;
	wire c_ctl      = cmd_code == tmms_pkg::CMD_STAT_CTRL;
	wire c_cfg2     = cmd_code == tmms_pkg::CMD_ADC_CFG2;

	wire c_known = c_vin_avg | c_vout_avg | c_iin_avg | c_tmp_avg | c_vin_min
		| c_vin_max | c_vout_min | c_iin_max | c_ctl | c_cfg2;

	// clear bits are actions, so they read back as zero
	wire [15:0] word_sel =
		c_vin_avg  ? tmms_pkg::word_of(avg_res[tmms_pkg::AV_VIN]) :
		c_vout_avg ? tmms_pkg::word_of(avg_res[tmms_pkg::AV_VOUT]) :
		c_iin_avg  ? tmms_pkg::word_of(avg_res[tmms_pkg::AV_IIN]) :
		c_tmp_avg  ? tmms_pkg::word_of(avg_res[tmms_pkg::AV_TMP]) :
		c_vin_min  ? tmms_pkg::word_of(pk_res[tmms_pkg::PK_VIN_MIN]) :
		c_vin_max  ? tmms_pkg::word_of(pk_res[tmms_pkg::PK_VIN_MAX]) :
		c_vout_min ? tmms_pkg::word_of(pk_res[tmms_pkg::PK_VOUT_MIN]) :
		c_iin_max  ? tmms_pkg::word_of(pk_res[tmms_pkg::PK_IIN_MAX]) :
		c_ctl      ? {13'h0000, cnt_r} :
		c_cfg2     ? {8'h00, cfg2_r} :
		tmms_pkg::WORD_ZERO;

	wire in_cmd  = state_r == tmms_pkg::ST_CMD;
	wire in_rdhi = state_r == tmms_pkg::ST_RDHI;
	wire rd_lo   = rd_req && !cmd_vld && in_cmd;
	wire rd_hi   = rd_req && !cmd_vld && in_rdhi;
	wire wr_take = wr_vld && !cmd_vld && in_cmd;
	wire wr_ctl  = wr_take && cmd_r == tmms_pkg::CMD_STAT_CTRL;
	wire wr_cfg  = wr_take && cmd_r == tmms_pkg::CMD_ADC_CFG2;

	// a new command code always restarts, as a repeated start does on the bus
	always_comb begin
		state_nxt = state_r;
		if (cmd_vld) begin
			state_nxt = tmms_pkg::ST_CMD;
		end else begin
			case (state_r)
				tmms_pkg::ST_CMD: begin
					if (rd_req) begin
						state_nxt = tmms_pkg::ST_RDHI;
					end else if (wr_vld) begin
						state_nxt = tmms_pkg::ST_IDLE;
					end
				end
				tmms_pkg::ST_RDHI: begin
					if (rd_req) begin
						state_nxt = tmms_pkg::ST_IDLE;
					end
				end
				default: state_nxt = tmms_pkg::ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			state_r <= tmms_pkg::ST_IDLE;
			cmd_r   <= 8'h00;
			word_r  <= tmms_pkg::WORD_ZERO;
			known_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			if (cmd_vld) begin
				// snapshot keeps both bytes from one sample
				cmd_r   <= cmd_code;
				word_r  <= word_sel;
				known_r <= c_known;
			end
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			cnt_r  <= tmms_pkg::CNT_RST;
			cfg2_r <= tmms_pkg::CFG2_RST;
		end else begin
			if (wr_ctl) begin
				cnt_r <= wr_byte[tmms_pkg::CTL_CNT_LSB +: tmms_pkg::SHW];
			end
			if (wr_cfg) begin
				cfg2_r <= wr_byte;
			end
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			clr_avg_r <= 1'b0;
			clr_min_r <= 1'b0;
			clr_pk_r  <= 1'b0;
		end else begin
			clr_avg_r <= wr_ctl && wr_byte[tmms_pkg::CTL_AVG_CLR];
			clr_min_r <= wr_ctl && wr_byte[tmms_pkg::CTL_MIN_CLR];
			clr_pk_r  <= wr_ctl && wr_byte[tmms_pkg::CTL_PK_CLR];
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			rd_byte_r <= tmms_pkg::BYTE_NONE;
			rd_vld_r  <= 1'b0;
			nack_r    <= 1'b0;
		end else begin
			rd_byte_r <= rd_lo ? word_r[7:0] : (rd_hi ? word_r[15:8] : tmms_pkg::BYTE_NONE);
			rd_vld_r  <= rd_lo || rd_hi;
			nack_r    <= (rd_req && !rd_lo && !rd_hi) || ((rd_lo || rd_hi || wr_take) && !known_r);
		end
	end

	vin_avg_cmd_a: assert property (@(posedge core_clk) disable iff (!resetn)
		cmd_vld && c_vin_avg |=> word_r == tmms_pkg::word_of($past(avg_res[tmms_pkg::AV_VIN])))
		else $error("input voltage average word wrong");
	vout_avg_cmd_a: assert property (@(posedge core_clk) disable iff (!resetn)
		cmd_vld && c_vout_avg |=> word_r == tmms_pkg::word_of($past(avg_res[tmms_pkg::AV_VOUT])))
		else $error("output voltage average word wrong");
	temp_sel_a: assert property (@(posedge core_clk) disable iff (!resetn)
		adc_vld && !clr_avg_r && cnt_r == 3'h0
		|=> avg_res[tmms_pkg::AV_TMP] == ($past(aux_sel) ? $past(vaux_code) : $past(temp_code)))
		else $error("temperature or aux average took wrong channel");
	sel_reset_a: assert property (@(posedge core_clk)
		$rose(resetn) |-> !aux_sel)
		else $error("channel select not low after reset");
	avg_clear_a: assert property (@(posedge core_clk) disable iff (!resetn)
		wr_ctl && wr_byte[tmms_pkg::CTL_AVG_CLR] |-> ##2 avg_res[tmms_pkg::AV_VIN] == tmms_pkg::CODE_ZERO
		&& avg_res[tmms_pkg::AV_IIN] == tmms_pkg::CODE_ZERO)
		else $error("average clear did not zero results");
	min_clear_a: assert property (@(posedge core_clk) disable iff (!resetn)
		wr_ctl && wr_byte[tmms_pkg::CTL_MIN_CLR] ##1 !adc_vld
		|=> pk_res[tmms_pkg::PK_VOUT_MIN] == tmms_pkg::CODE_MAX)
		else $error("minimum clear did not restart tracker");
	lo_first_a: assert property (@(posedge core_clk) disable iff (!resetn)
		cmd_vld ##1 (rd_req && !cmd_vld) |=> rd_vld_r && rd_byte_r == $past(word_r[7:0]))
		else $error("low byte not sent first");
	hi_zero_a: assert property (@(posedge core_clk) disable iff (!resetn)
		rd_hi && known_r && cmd_r != tmms_pkg::CMD_ADC_CFG2 |=> rd_vld_r && rd_byte_r[7:2] == 6'h00)
		else $error("upper result bits not zero");
	iin_avg_cmd_a: assert property (@(posedge core_clk) disable iff (!resetn)
		cmd_vld && c_iin_avg
		|=> word_r == tmms_pkg::word_of($past(avg_res[tmms_pkg::AV_IIN])))
		else $error("input current average word wrong");
	tmp_avg_cmd_a: assert property (@(posedge core_clk) disable iff (!resetn)
		cmd_vld && c_tmp_avg
		|=> word_r == tmms_pkg::word_of($past(avg_res[tmms_pkg::AV_TMP])))
		else $error("temperature or aux average word wrong");
	vin_min_cmd_a: assert property (@(posedge core_clk) disable iff (!resetn)
		cmd_vld && c_vin_min
		|=> word_r == tmms_pkg::word_of($past(pk_res[tmms_pkg::PK_VIN_MIN])))
		else $error("input voltage minimum word wrong");
	vin_max_cmd_a: assert property (@(posedge core_clk) disable iff (!resetn)
		cmd_vld && c_vin_max
		|=> word_r == tmms_pkg::word_of($past(pk_res[tmms_pkg::PK_VIN_MAX])))
		else $error("input voltage maximum word wrong");
	vout_min_cmd_a: assert property (@(posedge core_clk) disable iff (!resetn)
		cmd_vld && c_vout_min
		|=> word_r == tmms_pkg::word_of($past(pk_res[tmms_pkg::PK_VOUT_MIN])))
		else $error("output voltage minimum word wrong");
	iin_max_cmd_a: assert property (@(posedge core_clk) disable iff (!resetn)
		cmd_vld && c_iin_max
		|=> word_r == tmms_pkg::word_of($past(pk_res[tmms_pkg::PK_IIN_MAX])))
		else $error("input current maximum word wrong");
	hi_second_a: assert property (@(posedge core_clk) disable iff (!resetn)
		rd_hi
		|=> rd_vld_r && rd_byte_r == $past(word_r[15:8]))
		else $error("high byte not sent second");
	stray_nack_a: assert property (@(posedge core_clk) disable iff (!resetn)
		rd_req && !rd_lo && !rd_hi
		|=> nack_r && !rd_vld_r)
		else $error("read outside a word not refused");
	cnt_write_a: assert property (@(posedge core_clk) disable iff (!resetn)
		wr_ctl
		|=> cnt_r == $past(wr_byte[tmms_pkg::CTL_CNT_LSB +: tmms_pkg::SHW]))
		else $error("averaging count not taken");
	sel_write_a: assert property (@(posedge core_clk) disable iff (!resetn)
		wr_cfg
		|=> aux_sel == $past(wr_byte[tmms_pkg::CFG2_AUX_SEL]))
		else $error("channel select not taken");
	pk_clear_a: assert property (@(posedge core_clk) disable iff (!resetn)
		wr_ctl && wr_byte[tmms_pkg::CTL_PK_CLR] ##1 !adc_vld
		|=> pk_res[tmms_pkg::PK_IIN_MAX] == tmms_pkg::CODE_ZERO && pk_res[tmms_pkg::PK_VIN_MAX] == tmms_pkg::CODE_ZERO)
		else $error("peak clear did not restart trackers");
	idle_out_a: assert property (@(posedge core_clk) disable iff (!resetn)
		!rd_lo && !rd_hi
		|=> !rd_vld_r && rd_byte_r == tmms_pkg::BYTE_NONE)
		else $error("byte answered without a request");

	word_read_c: cover property (@(posedge core_clk) disable iff (!resetn)
		cmd_vld ##1 rd_lo ##[1:4] rd_hi);
	ctl_write_c: cover property (@(posedge core_clk) disable iff (!resetn)
		wr_ctl && wr_byte[tmms_pkg::CTL_PK_CLR]);
	aux_read_c: cover property (@(posedge core_clk) disable iff (!resetn)
		aux_sel && cmd_vld && c_tmp_avg);
	nack_seen_c: cover property (@(posedge core_clk) disable iff (!resetn)
		nack_r);
endmodule
`default_nettype wire

/* verification/tmms_host.sv */
// host model: issues command codes, read words and write bytes
`timescale 1ns/1ps
`default_nettype none
module tmms_host (
	input  wire logic       core_clk,
	output var  logic       cmd_vld,
	output var  logic [7:0] cmd_code,
	output var  logic       wr_vld,
	output var  logic [7:0] wr_byte,
	output var  logic       rd_req
);
	initial begin
		cmd_vld = 1'b0;
		cmd_code = 8'h00;
		wr_vld = 1'b0;
		wr_byte = 8'h00;
		rd_req = 1'b0;
	end

	// released lines show the inverse so a stale value is never mistaken for valid data
	task automatic send_cmd(input logic [7:0] c);
		@(posedge core_clk);
		#1;
		cmd_vld = 1'b1;
		cmd_code = c;
		@(posedge core_clk);
		#1;
		cmd_vld = 1'b0;
		cmd_code = ~c;
	endtask

	// command first, then n byte requests on consecutive edges
	task automatic rd_seq(input logic [7:0] c, input int n);
		send_cmd(c);
		repeat (n) begin
			rd_req = 1'b1;
			@(posedge core_clk);
			#1;
		end
		rd_req = 1'b0;
		repeat (3) @(posedge core_clk);
	endtask

	task automatic read_word(input logic [7:0] c);
		rd_seq(c, 2);
	endtask

	task automatic write_byte(input logic [7:0] c, input logic [7:0] b);
		send_cmd(c);
		wr_vld = 1'b1;
		wr_byte = b;
		@(posedge core_clk);
		#1;
		wr_vld = 1'b0;
		wr_byte = ~b;
		repeat (3) @(posedge core_clk);
	endtask
endmodule
`default_nettype wire

/* verification/testbench.sv */
// self-checking bench for the telemetry statistics block
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic       core_clk, resetn, adc_vld, cmd_vld, wr_vld, rd_req, rd_vld_r, nack_r;
	logic [9:0] vin, vout, iin, tmp, vaux;
	logic [7:0] cmd_code, wr_byte, rd_byte_r;
	int         fail_count, cmp_count;
	logic [9:0] q[$];
	logic [9:0] e;
	logic [15:0] last_word;
	logic [9:0] a_vin, a_vout, a_iin, a_tmp, m_vin_mn, m_vin_mx, m_vout_mn, m_iin_mx;
	logic       aux_sel;

	tmms_top u_dut (.core_clk(core_clk), .resetn(resetn), .adc_vld(adc_vld), .vin_code(vin), .vout_code(vout),
		.iin_code(iin), .temp_code(tmp), .vaux_code(vaux), .cmd_vld(cmd_vld), .cmd_code(cmd_code),
		.wr_vld(wr_vld), .wr_byte(wr_byte), .rd_req(rd_req), .rd_byte_r(rd_byte_r), .rd_vld_r(rd_vld_r),
		.nack_r(nack_r));
	tmms_host u_host (.core_clk(core_clk), .cmd_vld(cmd_vld), .cmd_code(cmd_code), .wr_vld(wr_vld),
		.wr_byte(wr_byte), .rd_req(rd_req));

	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end

	task automatic check(input logic [8:0] seen, input logic [8:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// answers are registered, so the falling edge sees them settled
	always @(negedge core_clk) begin
		if (rd_vld_r === 1'b1 || nack_r === 1'b1) begin
			if (rd_vld_r === 1'b1)
				last_word = {rd_byte_r, last_word[15:8]};
			if (q.size() == 0)
				check({7'h00, rd_vld_r, nack_r}, 9'h000);
			else begin
				e = q.pop_front();
				if (e[9])
					check({nack_r, rd_byte_r}, e[8:0]);
			end
		end
	end

	task automatic rd(input logic [7:0] c, input logic [9:0] v, input logic care);
		q.push_back({care, 1'b0, v[7:0]});
		q.push_back({care, 1'b0, 6'h00, v[9:8]});
		u_host.read_word(c);
	endtask

	task automatic adc(input logic [9:0] a, input logic [9:0] b, input logic [9:0] c, input logic [9:0] d,
		input logic [9:0] x);
		@(posedge core_clk);
		#1;
		{vin, vout, iin, tmp, vaux} = {a, b, c, d, x};
		adc_vld = 1'b1;
		{a_vin, a_vout, a_iin, a_tmp} = {a, b, c, aux_sel ? x : d};
		if (a < m_vin_mn) m_vin_mn = a;
		if (a > m_vin_mx) m_vin_mx = a;
		if (b < m_vout_mn) m_vout_mn = b;
		if (c > m_iin_mx) m_iin_mx = c;
		@(posedge core_clk);
		#1;
		adc_vld = 1'b0;
		{vin, vout, iin, tmp, vaux} = ~{a, b, c, d, x};
	endtask

	task automatic adc_rnd();
		adc(10'($urandom), 10'($urandom), 10'($urandom), 10'($urandom), 10'($urandom));
	endtask

	task automatic check_all();
		rd(tmms_pkg::CMD_VIN_AVG, a_vin, 1'b1);
		rd(tmms_pkg::CMD_VIN_MIN, m_vin_mn, 1'b1);
		rd(tmms_pkg::CMD_VIN_MAX, m_vin_mx, 1'b1);
		rd(tmms_pkg::CMD_VOUT_AVG, a_vout, 1'b1);
		rd(tmms_pkg::CMD_VOUT_MIN, m_vout_mn, 1'b1);
		rd(tmms_pkg::CMD_IIN_AVG, a_iin, 1'b1);
		rd(tmms_pkg::CMD_IIN_MAX, m_iin_mx, 1'b1);
		rd(tmms_pkg::CMD_TEMP_AVG, a_tmp, 1'b1);
	endtask

	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial begin
		#100000;
		fail_count++;
		$display("ERROR t=%0t seen=%h exp=%h", $time, 1'b0, 1'b1);
		finish_test();
	end

	initial begin
		{resetn, adc_vld, vin, vout, iin, tmp, vaux} = '0;
		{fail_count, cmp_count, last_word, aux_sel} = '0;
		{a_vin, a_vout, a_iin, a_tmp, m_vin_mx, m_iin_mx} = '0;
		{m_vin_mn, m_vout_mn} = {2{10'h3FF}};
		void'($urandom(32'h6B37));
		repeat (12) @(posedge core_clk);
		#1;
		resetn = 1'b1;
		check_all();
		rd(tmms_pkg::CMD_STAT_CTRL, 10'h000, 1'b1);
		rd(tmms_pkg::CMD_ADC_CFG2, 10'h000, 1'b1);
		$display("test reset_values done");
		adc(10'h3FF, 10'h000, 10'h3FF, 10'h000, 10'h3FF);
		repeat (20) adc_rnd();
		adc(10'h000, 10'h3FF, 10'h000, 10'h3FF, 10'h000);
		check_all();
		$display("test running_stats done");
		u_host.write_byte(tmms_pkg::CMD_ADC_CFG2, 8'h80);
		aux_sel = 1'b1;
		adc_rnd();
		rd(tmms_pkg::CMD_TEMP_AVG, a_tmp, 1'b1);
		rd(tmms_pkg::CMD_ADC_CFG2, 10'h080, 1'b1);
		$display("test aux_select done");
		// each clear alone, so a clear bit that hits the wrong trackers shows up
		u_host.write_byte(tmms_pkg::CMD_STAT_CTRL, 8'h20);
		{m_vin_mn, m_vout_mn} = {2{10'h3FF}};
		check_all();
		u_host.write_byte(tmms_pkg::CMD_STAT_CTRL, 8'h80);
		{m_vin_mx, m_iin_mx} = '0;
		check_all();
		u_host.write_byte(tmms_pkg::CMD_STAT_CTRL, 8'h40);
		{a_vin, a_vout, a_iin, a_tmp} = '0;
		check_all();
		adc_rnd();
		check_all();
		$display("test clears done");
		u_host.write_byte(tmms_pkg::CMD_STAT_CTRL, 8'h43);
		adc(10'h300, 10'h300, 10'h300, 10'h300, 10'h300);
		rd(tmms_pkg::CMD_VIN_AVG, 10'h000, 1'b0);
		check({8'h00, last_word > 16'h0000 && last_word < 16'h0300}, 9'h001);
		rd(tmms_pkg::CMD_STAT_CTRL, 10'h003, 1'b1);
		$display("test avg_count done");
		// an unknown command still answers both bytes as zero, flagged by nack
		q.push_back(10'h300);
		q.push_back(10'h300);
		u_host.rd_seq(8'h55, 2);
		rd(tmms_pkg::CMD_VIN_MIN, m_vin_mn, 1'b1);
		q.push_back({2'b10, m_vin_mn[7:0]});
		q.push_back({2'b10, 6'h00, m_vin_mn[9:8]});
		q.push_back(10'h3FF);
		u_host.rd_seq(tmms_pkg::CMD_VIN_MIN, 3);
		q.push_back(10'h3FF);
		u_host.write_byte(8'h55, 8'h00);
		check({8'h00, q.size() == 0}, 9'h001);
		$display("test refusals done");
		// reset again with aux selected, so the select default is really exercised
		@(posedge core_clk);
		#1;
		resetn = 1'b0;
		repeat (2) @(posedge core_clk);
		#1;
		resetn = 1'b1;
		{aux_sel, a_vin, a_vout, a_iin, a_tmp, m_vin_mx, m_iin_mx} = '0;
		{m_vin_mn, m_vout_mn} = {2{10'h3FF}};
		check_all();
		rd(tmms_pkg::CMD_ADC_CFG2, 10'h000, 1'b1);
		$display("test mid_reset done");
		finish_test();
	end
endmodule
`default_nettype wire
